// [inc/bwd_pkg.sv]
// Package: constants and types of the board watchdog and reset collector
package bwd_pkg;
  // ==========================================
  // Clock and timing
  localparam int CLK_HZ = 40000000;
  localparam int STEP_MIN_MS = 125;
  localparam int STEP_COUNT = 12;
  localparam int STEP_W = 4;
  localparam int MS_PER_S = 1000;
  // Cycles per 125 ms base tick
  localparam int BASE_TICK_CYC = (CLK_HZ / MS_PER_S) * STEP_MIN_MS;
  // Step 11 is 125 ms * 2**11 = 256 s, counted in base ticks
  localparam int TICK_W = 12;
  localparam int RST_PULSE_MS = 1;
  localparam int RST_PULSE_CYC = (CLK_HZ / MS_PER_S) * RST_PULSE_MS;
  localparam logic [STEP_W-1:0] STEP_MAX = 4'hB;
  // ==========================================
  // Expiry actions
  typedef enum logic [1:0] {
    BWD_ACT_LINE5 = 2'h0,
    BWD_ACT_NMI = 2'h1,
    BWD_ACT_RESET = 2'h2
  } bwd_action_t;
  // ==========================================
  // Reset sequencer states, Gray coded except STRETCH to RUN
  typedef enum logic [1:0] {
    BWD_RS_RUN = 2'h0,
    BWD_RS_HOLD = 2'h1,
    BWD_RS_STRETCH = 2'h3
  } bwd_rst_state_t;
endpackage

// [hw/bwd_sync.sv]
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module bwd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } bwd_sync_state_t;
  bwd_sync_state_t s_q;
  bwd_sync_state_t s_d;

  // ==========================================
  // Next state: first stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end

  // Reset to idle-high: all inputs are active-low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{meta: '1, sync: '1};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.sync;
endmodule

// [hw/bwd_top.sv]
// Board watchdog timer with reset collection logic
`timescale 1ns/1ps
// Summary of operation
// RULE1: On expiry exactly one configured action fires: line five IRQ, NMI, or board reset.
// RULE2: Timeout chooses one of twelve steps from 125 ms to 256 s (doubling).
// RULE3: Once enabled the watchdog cannot be disabled; only reset clears it.
// RULE4: Expiry with the reset action, push-button or bridge request resets the board and local peripherals.
// RULE5: Board is held in reset while any supply-fail indication is active.
// RULE6: The yellow status indicator is on exactly while the watchdog is enabled.
// RULE7: Software retriggers before timeout; each retrigger restarts the full interval.
module bwd_top
  import bwd_pkg::*;
#(
  parameter int BASE_CYC = bwd_pkg::BASE_TICK_CYC,
  parameter int PULSE_CYC = bwd_pkg::RST_PULSE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wd_write,
  input wire logic i_wd_enable,
  input wire logic [bwd_pkg::STEP_W-1:0] i_wd_step,
  input wire logic [1:0] i_wd_action,
  input wire logic i_button_b,
  input wire logic i_bridge_rst_b,
  input wire logic i_v5_fail_b,
  input wire logic i_v33_fail_b,
  input wire logic i_dcdc_fail_b,
  output logic o_interrupt_line_five,
  output logic o_nmi,
  output logic o_board_rst_b,
  output logic o_periph_rst_b,
  output logic o_watchdog_status_indicator,
  output logic o_wd_enabled
);
  import bwd_pkg::*;

  // Bit positions of the synchronised reset and supply-fail pins
  localparam int SRC_N = 5;
  localparam int SRC_BUTTON = 4;
  localparam int SRC_BRIDGE = 3;
  localparam int SRC_V5 = 2;
  localparam int SRC_V33 = 1;
  localparam int SRC_DCDC = 0;
  localparam int BASE_W = $clog2(BASE_CYC + 1);
  localparam int PULSE_W = $clog2(PULSE_CYC + 1);

  typedef struct packed {
    logic enabled;
    logic [STEP_W-1:0] step;
    bwd_action_t action;
    logic [BASE_W-1:0] base_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic irq;
    logic nmi;
    logic expire;
    bwd_rst_state_t rst_st;
    logic [PULSE_W-1:0] pulse_cnt;
  } bwd_state_t;
  bwd_state_t s_q;
  bwd_state_t s_d;

  logic [SRC_N-1:0] sync_b;
  logic button_b;
  logic bridge_b;
  logic power_bad;
  logic ext_req;
  logic timeout;

  // Ticks needed for a step: 2**step base periods
  function automatic logic [TICK_W-1:0] step_ticks(input logic [STEP_W-1:0] step);
    logic [STEP_W-1:0] s;
    s = (step > STEP_MAX) ? STEP_MAX : step;
    step_ticks = TICK_W'(1) << s;
  endfunction

  // ==========================================
  // Pin synchronisation
  bwd_sync #(
    .WIDTH(SRC_N)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_button_b, i_bridge_rst_b, i_v5_fail_b, i_v33_fail_b, i_dcdc_fail_b}),
    .o_sync(sync_b)
  );

  // Power failure and external requests act alike; neither outranks the other
  assign button_b = sync_b[SRC_BUTTON];
  assign bridge_b = sync_b[SRC_BRIDGE];
  assign power_bad = ~sync_b[SRC_V5] | ~sync_b[SRC_V33] | ~sync_b[SRC_DCDC]; // see RULE5
  assign ext_req = ~button_b | ~bridge_b; // see RULE4
  assign timeout = s_q.enabled && (s_q.tick_cnt == step_ticks(s_q.step));

  // ==========================================
  // Watchdog and reset sequencer next state
  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    // Config writes: enable is sticky, settings locked once running
    if (i_wd_write) begin
      if (!s_q.enabled) begin
        s_d.step = (i_wd_step > STEP_MAX) ? STEP_MAX : i_wd_step; // see RULE2
        s_d.action = bwd_action_t'(i_wd_action);
        s_d.enabled = i_wd_enable; // see RULE3
      end
      // Any write is a retrigger: restart full interval
      s_d.base_cnt = '0; // see RULE7
      s_d.tick_cnt = '0;
    end else if (s_q.enabled) begin
      if (timeout) begin
        s_d.expire = 1'b1;
        s_d.base_cnt = '0;
        s_d.tick_cnt = '0;
      end else if (s_q.base_cnt == BASE_W'(BASE_CYC - 1)) begin
        s_d.base_cnt = '0;
        s_d.tick_cnt = s_q.tick_cnt + TICK_W'(1); // see RULE2
      end else begin
        s_d.base_cnt = s_q.base_cnt + BASE_W'(1);
      end
    end
    // Exactly one action per expiry; interrupts stay until retrigger or board reset
    if (timeout) begin
      case (s_q.action)
        BWD_ACT_LINE5: s_d.irq = 1'b1; // see RULE1
        BWD_ACT_NMI: s_d.nmi = 1'b1; // see RULE1
        default: ;
      endcase
    end else if (i_wd_write) begin
      s_d.irq = 1'b0;
      s_d.nmi = 1'b0;
    end
    // Reset sequencer: hold while a source is active, then stretch
    case (s_q.rst_st)
      BWD_RS_RUN: begin
        if (power_bad || ext_req ||
            (timeout && s_q.action == BWD_ACT_RESET)) begin // see RULE4
          s_d.rst_st = BWD_RS_HOLD;
        end
      end
      BWD_RS_HOLD: begin
        s_d.pulse_cnt = '0;
        if (!power_bad && !ext_req) begin
          s_d.rst_st = BWD_RS_STRETCH;
        end
      end
      BWD_RS_STRETCH: begin
        if (power_bad || ext_req) begin
          s_d.rst_st = BWD_RS_HOLD;
        end else if (s_q.pulse_cnt == PULSE_W'(PULSE_CYC - 1)) begin
          s_d.rst_st = BWD_RS_RUN;
        end else begin
          s_d.pulse_cnt = s_q.pulse_cnt + PULSE_W'(1);
        end
      end
      default: s_d.rst_st = BWD_RS_HOLD;
    endcase
    // Board reset also clears the watchdog, as a power-on would
    if (s_q.rst_st != BWD_RS_RUN) begin
      s_d.enabled = 1'b0; // see RULE3
      s_d.irq = 1'b0;
      s_d.nmi = 1'b0;
      s_d.base_cnt = '0;
      s_d.tick_cnt = '0;
    end
  end

  // State register; comes up in hold so the board starts in reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{enabled: 1'b0, step: '0, action: BWD_ACT_LINE5, base_cnt: '0,
               tick_cnt: '0, irq: 1'b0, nmi: 1'b0, expire: 1'b0,
               rst_st: BWD_RS_HOLD, pulse_cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs, all from flip-flops
  assign o_interrupt_line_five = s_q.irq;
  assign o_nmi = s_q.nmi;
  assign o_board_rst_b = (s_q.rst_st == BWD_RS_RUN); // see RULE4
  assign o_periph_rst_b = (s_q.rst_st == BWD_RS_RUN); // see RULE4
  assign o_watchdog_status_indicator = s_q.enabled; // see RULE6
  assign o_wd_enabled = s_q.enabled;

  // ==========================================
  // Checks
  AST_ONE_ACTION: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE1
    s_q.expire |-> !(s_q.irq && s_q.nmi))
    else $error("both interrupt actions raised");
  AST_IRQ_ON_EXPIRY: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE1
    (timeout && s_q.action == BWD_ACT_LINE5 && s_q.rst_st == BWD_RS_RUN) |=> s_q.irq)
    else $error("line five not raised on expiry");
  AST_NMI_ON_EXPIRY: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE1
    (timeout && s_q.action == BWD_ACT_NMI && s_q.rst_st == BWD_RS_RUN) |=> s_q.nmi)
    else $error("nmi not raised on expiry");
  AST_RESET_ON_EXPIRY: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE4
    (timeout && s_q.action == BWD_ACT_RESET) |=> !o_board_rst_b)
    else $error("board reset not raised on expiry");
  AST_STEP_RANGE: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE2
    s_q.step <= STEP_MAX)
    else $error("timeout step out of range");
  AST_NO_DISABLE: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE3
    (s_q.enabled && s_q.rst_st == BWD_RS_RUN) |=> s_q.enabled)
    else $error("watchdog disabled while running");
  AST_POWER_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE5
    power_bad |=> !o_board_rst_b ##1 !o_board_rst_b)
    else $error("board left reset during power fail");
  AST_BUTTON_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE4
    !button_b |=> (!o_board_rst_b && !o_periph_rst_b))
    else $error("button did not reset board");
  AST_LED: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE6
    (i_wd_write && i_wd_enable && s_q.rst_st == BWD_RS_RUN) |=> o_watchdog_status_indicator)
    else $error("indicator does not follow enable");
  AST_RETRIGGER: assert property (@(posedge i_clk) disable iff (!i_rst_b) // see RULE7
    (i_wd_write && s_q.enabled) |=> (s_q.tick_cnt == '0 && s_q.base_cnt == '0))
    else $error("retrigger did not restart count");
endmodule

// [verification/bwd_host.sv]
// Partner model: host software writes and board reset sources
`timescale 1ns/1ps
module bwd_host (
  input wire logic i_clk,
  output logic o_wd_write,
  output logic o_wd_enable,
  output logic [bwd_pkg::STEP_W-1:0] o_wd_step,
  output logic [1:0] o_wd_action,
  output logic [4:0] o_src_b
);
  import bwd_pkg::*;
  // ==========
  // Idle: no write, every source inactive (high)
  initial begin
    {o_wd_write, o_wd_enable, o_wd_step, o_wd_action} = '0;
    o_src_b = 5'h1F;
  end
  // One-cycle write; also the retrigger that restarts the count
  task automatic wr(input logic en, input logic [STEP_W-1:0] st, input logic [1:0] act);
    @(negedge i_clk);
    {o_wd_write, o_wd_enable, o_wd_step, o_wd_action} = {1'b1, en, st, act};
    @(negedge i_clk);
    // Fields scrambled so a late sample shows up
    {o_wd_write, o_wd_enable, o_wd_step, o_wd_action} = {1'b0, ~en, ~st, ~act};
  endtask
  // Source 0 button, 1 bridge, 2..4 supply fails; low for len cycles
  task automatic src(input int idx, input int len);
    @(negedge i_clk);
    o_src_b[idx] = 1'b0;
    repeat (len) @(negedge i_clk);
    o_src_b[idx] = 1'b1;
  endtask
endmodule

// [verification/bwd_top_test.sv]
// Self-checking bench of the board watchdog and reset collector
`timescale 1ns/1ps
module bwd_top_test;
  import bwd_pkg::*;
  // Short counts keep the longest step near 20k cycles
  localparam int BASE = 10;
  localparam int PULSE = 4;
  logic clk, rst_b, wr, en, irq, nmi, brst_b, prst_b, led, ena;
  logic [STEP_W-1:0] step;
  logic [1:0] act;
  logic [4:0] src_b;
  int fails, checks, n, s;
  bwd_host host (.i_clk(clk), .o_wd_write(wr), .o_wd_enable(en), .o_wd_step(step),
    .o_wd_action(act), .o_src_b(src_b));
  bwd_top #(.BASE_CYC(BASE), .PULSE_CYC(PULSE)) uut (.i_clk(clk), .i_rst_b(rst_b),
    .i_wd_write(wr), .i_wd_enable(en), .i_wd_step(step), .i_wd_action(act),
    .i_button_b(src_b[0]), .i_bridge_rst_b(src_b[1]), .i_v5_fail_b(src_b[2]),
    .i_v33_fail_b(src_b[3]), .i_dcdc_fail_b(src_b[4]), .o_interrupt_line_five(irq),
    .o_nmi(nmi), .o_board_rst_b(brst_b), .o_periph_rst_b(prst_b),
    .o_watchdog_status_indicator(led), .o_wd_enabled(ena));
  // ==========
  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Expected timeout in cycles for a step
  function automatic int exp_cyc(input int st);
    return (1 << st) * BASE;
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for board reset release; n keeps the cycle count
  task automatic wait_up();
    n = 0;
    while (brst_b !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n < 100, "board reset stuck");
    if (n >= 100) conclude();
  endtask
  // ==========
  // Arm, try to disable halfway, time the expiry, then recover
  task automatic expire(input int st, input logic [1:0] a);
    host.wr(1'b1, st[STEP_W-1:0], a);
    chk(ena === 1'b1 && led === 1'b1, "not enabled");
    repeat (exp_cyc(st) / 2) @(negedge clk);
    host.wr(1'b0, 4'h0, a + 2'h1);
    chk(ena === 1'b1 && led === 1'b1, "disable accepted");
    n = 0;
    while (irq !== 1'b1 && nmi !== 1'b1 && brst_b !== 1'b0 && n < exp_cyc(st) + 10) begin
      @(negedge clk);
      n++;
    end
    chk(n >= exp_cyc(st) - 1 && n <= exp_cyc(st) + 3, "wrong timeout");
    chk(irq === (a == 2'h0) && nmi === (a == 2'h1), "interrupt action");
    chk(brst_b === (a != 2'h2), "reset action");
    if (a != 2'h2) host.src(0, 4);
    chk(brst_b === 1'b0 && prst_b === 1'b0, "no board reset");
    wait_up();
    chk({ena, led, irq, nmi} === 4'h0, "watchdog not cleared");
  endtask
  // ==========
  // Main sequence
  initial begin
    rst_b = 1'b0;
    s = $urandom(91);
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    wait_up();
    chk(led === 1'b0 && ena === 1'b0, "enabled after reset");
    for (int a = 0; a < 3; a++) expire($urandom_range(3, 0), a[1:0]);
    expire(0, 2'h1);
    expire(11, 2'h0);
    // Bridge request, then each supply fail; stretch measured on release
    for (int i = 1; i < 5; i++) begin
      host.src(i, 6 + $urandom_range(4, 0));
      chk(brst_b === 1'b0 && prst_b === 1'b0, "source ignored");
      wait_up();
      chk(n >= PULSE && n <= PULSE + 4, "bad stretch");
    end
    conclude();
  end
endmodule
